// File: rsb_pkg.sv
// Package for the result status byte builder
package rsb_pkg;
    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    localparam logic [2:0] data_port_offset = 3'h5;
    localparam logic [1:0] sel_zero = 2'h0;
    localparam logic [1:0] sel_one = 2'h1;
    localparam logic [1:0] sel_two = 2'h2;
    localparam logic [1:0] sel_three = 2'h3;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int zero_head_bit = 2;
    localparam int zero_equip_bit = 4;
    localparam int zero_seek_bit = 5;
    localparam int one_addr_mark_bit = 0;
    localparam int one_wprot_bit = 1;
    localparam int one_missing_bit = 2;
    localparam int one_overrun_bit = 4;
    localparam int one_crc_bit = 5;
    localparam int one_eot_bit = 7;
    localparam int two_am_loc_bit = 0;
    localparam int two_bad_trk_bit = 1;
    localparam int two_scan_ns_bit = 2;
    localparam int two_scan_eq_bit = 3;
    localparam int two_wrong_trk_bit = 4;
    localparam int two_crc_data_bit = 5;
    localparam int two_ctrl_mark_bit = 6;
    localparam int three_track_zero_bit = 4;
    localparam int three_wprot_bit = 6;
    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] ic_normal = 2'h0;
    localparam logic [1:0] ic_abnormal = 2'h1;
    localparam logic [1:0] ic_invalid = 2'h2;
    localparam logic [1:0] ic_ready_change = 2'h3;
    localparam logic [7:0] three_fixed_ones = 8'h28;
    localparam logic [7:0] byte_reset = 8'h00;
    localparam logic [7:0] bad_track_number = 8'hff;
    // ------------------------------------------------------------
    // Termination events from the execution engine
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        rsb_end_normal,
        rsb_end_abnormal,
        rsb_end_invalid
    } rsb_end_e;
endpackage

// File: rsb_status.sv
// Result phase status byte builder and data port read mux
`timescale 1ns/1ns
`default_nettype none
// How it works
// R1 - Result bytes read via data port 05h
// R2 - Result bytes readable only in result phase
// R3 - Byte zero bits 1,0 hold drive
// R4 - Byte zero bit 2 latches head side
// R5 - Unused bits of bytes zero-two read 0
// R6 - Equipment check when recalibrate misses track zero
// R7 - Seek end set after seek or recalibrate
// R8 - Bits 7,6 hold interrupt reason code
// R9 - Ready-change code only after reset
// R10 - Missing address mark flag on reads
// R11 - Write protect flag on write, format
// R12 - Missing data flag, two causes
// R13 - Overrun or underrun flag
// R14 - CRC flag plus data-or-address location
// R15 - End of track without terminal count
// R16 - Address mark location bit
// R17 - Bad track when recorded track FFh
// R18 - Scan not satisfied flag
// R19 - Scan equal found flag
// R20 - Wrong track flag
// R21 - Control mark flag on mark mismatch
// R22 - Byte three drive from command phase
// R23 - Byte three track zero live input
// R24 - Byte three write protect active low
// R25 - Byte three bits 3,5 read 1
// R26 - New command clears condition flags
module rsb_status
(
    input wire logic clk,
    input wire logic reset,
    input wire logic soft_reset,
    input wire logic [2:0] host_addr,
    input wire logic host_rd,
    input wire logic result_phase,
    input wire logic [1:0] result_sel,
    input wire logic cmd_start,
    input wire logic cmd_phase_end,
    input wire logic exec_end,
    input wire logic [1:0] end_kind,
    input wire logic [1:0] drive_sel,
    input wire logic head_side_select,
    input wire logic poll_ready_change,
    input wire logic seek_done,
    input wire logic recal_done,
    input wire logic track_zero_seen,
    input wire logic ev_addr_mark_missing,
    input wire logic ev_am_in_data_field,
    input wire logic is_write_cmd,
    input wire logic ev_sector_not_found,
    input wire logic [7:0] recorded_track,
    input wire logic [7:0] command_track,
    input wire logic ev_missing_data,
    input wire logic ev_overrun,
    input wire logic ev_crc_error,
    input wire logic ev_crc_in_data,
    input wire logic ev_last_byte_eot,
    input wire logic terminal_count,
    input wire logic ev_scan_result,
    input wire logic scan_cond_met,
    input wire logic ev_scan_equal,
    input wire logic ev_control_mark,
    input wire logic track_zero_input_n,
    input wire logic write_protect_n,
    output logic [7:0] rd_data,
    output logic rd_data_valid
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [7:0] zero;
        logic [7:0] one;
        logic [7:0] two;
        logic [1:0] drive3;
        logic head3;
        logic reset_seen;
        logic [2:0] tz_sync;
        logic [2:0] wp_sync;
        logic tz;
        logic wp;
        logic [7:0] rd_data;
        logic rd_data_valid;
    } rsb_state_s;

    rsb_state_s st_ff;
    rsb_state_s nxt_st;

    // Pin filter: accept change once stages two and three agree
    function automatic logic filt(input logic [2:0] s, input logic old);
        filt = (s[1] == s[2]) ? s[2] : old;
    endfunction

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tz_sync = {st_ff.tz_sync[1:0], ~track_zero_input_n};
        nxt_st.wp_sync = {st_ff.wp_sync[1:0], ~write_protect_n};
        nxt_st.tz = filt(st_ff.tz_sync, st_ff.tz);
        nxt_st.wp = filt(st_ff.wp_sync, st_ff.wp);
        if (soft_reset)
        begin
            nxt_st.reset_seen = 1'b1;
        end
        // ------------------------------------------------------------
        // Command start
        // ------------------------------------------------------------
        // R26 fresh flags
        if (cmd_start)
        begin
            nxt_st.zero = rsb_pkg::byte_reset;
            nxt_st.one = rsb_pkg::byte_reset;
            nxt_st.two = rsb_pkg::byte_reset;
        end
        // R22 drive at command end
        if (cmd_phase_end)
        begin
            nxt_st.drive3 = drive_sel;
            nxt_st.head3 = head_side_select;
        end
        // ------------------------------------------------------------
        // Execution events; sets beat the start clear
        // ------------------------------------------------------------
        // R10 address mark missing
        if (ev_addr_mark_missing)
        begin
            nxt_st.one[rsb_pkg::one_addr_mark_bit] = 1'b1;
            // R16 mark location
            nxt_st.two[rsb_pkg::two_am_loc_bit] = ev_am_in_data_field;
        end
        // R11 write protect sample
        if (is_write_cmd && cmd_phase_end)
        begin
            nxt_st.one[rsb_pkg::one_wprot_bit] = st_ff.wp;
        end
        // R12 missing data
        if (ev_missing_data || ev_sector_not_found)
        begin
            nxt_st.one[rsb_pkg::one_missing_bit] = 1'b1;
        end
        // R20 wrong track
        if (ev_sector_not_found && recorded_track != command_track)
        begin
            nxt_st.two[rsb_pkg::two_wrong_trk_bit] = 1'b1;
            // R17 bad track marker
            if (recorded_track == rsb_pkg::bad_track_number)
            begin
                nxt_st.two[rsb_pkg::two_bad_trk_bit] = 1'b1;
            end
        end
        // R13 late host service
        if (ev_overrun)
        begin
            nxt_st.one[rsb_pkg::one_overrun_bit] = 1'b1;
        end
        // R14 crc and where
        if (ev_crc_error)
        begin
            nxt_st.one[rsb_pkg::one_crc_bit] = 1'b1;
            nxt_st.two[rsb_pkg::two_crc_data_bit] = ev_crc_in_data;
        end
        // R15 end of track
        if (ev_last_byte_eot && !terminal_count)
        begin
            nxt_st.one[rsb_pkg::one_eot_bit] = 1'b1;
        end
        // R18 scan condition
        if (ev_scan_result)
        begin
            nxt_st.two[rsb_pkg::two_scan_ns_bit] = ~scan_cond_met;
        end
        // R19 scan equal
        if (ev_scan_equal)
        begin
            nxt_st.two[rsb_pkg::two_scan_eq_bit] = 1'b1;
        end
        // R21 control mark
        if (ev_control_mark)
        begin
            nxt_st.two[rsb_pkg::two_ctrl_mark_bit] = 1'b1;
        end
        // R7 seek end
        if (seek_done || recal_done)
        begin
            nxt_st.zero[rsb_pkg::zero_seek_bit] = 1'b1;
        end
        // R6 equipment check
        if (recal_done)
        begin
            nxt_st.zero[rsb_pkg::zero_equip_bit] = ~track_zero_seen;
        end
        // ------------------------------------------------------------
        // Execution end: drive, head, reason
        // ------------------------------------------------------------
        if (exec_end)
        begin
            // R3 drive field
            nxt_st.zero[1:0] = drive_sel;
            // R4 head latch
            nxt_st.zero[rsb_pkg::zero_head_bit] = head_side_select;
            // R8 reason code
            unique case (end_kind)
                rsb_pkg::rsb_end_abnormal: nxt_st.zero[7:6] = rsb_pkg::ic_abnormal;
                rsb_pkg::rsb_end_invalid: nxt_st.zero[7:6] = rsb_pkg::ic_invalid;
                default: nxt_st.zero[7:6] = rsb_pkg::ic_normal;
            endcase
        end
        // R9 polling code gated by reset history
        if (poll_ready_change && st_ff.reset_seen)
        begin
            nxt_st.zero[7:6] = rsb_pkg::ic_ready_change;
            nxt_st.reset_seen = 1'b0;
        end
        // R5 unused bits forced low
        nxt_st.zero[3] = 1'b0;
        nxt_st.one[3] = 1'b0;
        nxt_st.one[6] = 1'b0;
        nxt_st.two[7] = 1'b0;
        // ------------------------------------------------------------
        // Data port read
        // ------------------------------------------------------------
        nxt_st.rd_data = rsb_pkg::byte_reset;
        nxt_st.rd_data_valid = 1'b0;
        // R1 data port decode
        // R2 result phase only
        if (host_rd && host_addr == rsb_pkg::data_port_offset && result_phase)
        begin
            nxt_st.rd_data_valid = 1'b1;
            unique case (result_sel)
                rsb_pkg::sel_zero: nxt_st.rd_data = st_ff.zero;
                rsb_pkg::sel_one: nxt_st.rd_data = st_ff.one;
                rsb_pkg::sel_two: nxt_st.rd_data = st_ff.two;
                rsb_pkg::sel_three:
                begin
                    // R25 fixed ones
                    nxt_st.rd_data = rsb_pkg::three_fixed_ones;
                    // R22 drive field
                    nxt_st.rd_data[1:0] = st_ff.drive3;
                    nxt_st.rd_data[rsb_pkg::zero_head_bit] = st_ff.head3;
                    // R23 track zero
                    nxt_st.rd_data[rsb_pkg::three_track_zero_bit] = st_ff.tz;
                    // R24 write protect
                    nxt_st.rd_data[rsb_pkg::three_wprot_bit] = st_ff.wp;
                end
            endcase
        end
    end

    // Hardware reset also arms the ready-change report
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_ff <= '0;
            st_ff.reset_seen <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data = st_ff.rd_data;
    assign rd_data_valid = st_ff.rd_data_valid;
endmodule // rsb_status
`default_nettype wire

// File: rsb_status_assertions.sv
// Checker for the result status byte builder
`timescale 1ns/1ns
`default_nettype none
module rsb_status_checker
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] host_addr,
    input wire logic host_rd,
    input wire logic result_phase,
    input wire logic [1:0] result_sel,
    input wire logic exec_end,
    input wire logic [1:0] end_kind,
    input wire logic [1:0] drive_sel,
    input wire logic head_side_select,
    input wire logic poll_ready_change,
    input wire logic [7:0] rd_data,
    input wire logic rd_data_valid
);
    // --------
    // Read port
    // --------
    logic rd_req;
    assign rd_req = host_rd && host_addr == rsb_pkg::data_port_offset && result_phase;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    rd_take_a: assert property (rd_req |=> rd_data_valid)
        else $error("read not answered");
    rd_refuse_a: assert property (!rd_req |=> !rd_data_valid)
        else $error("read answered outside result phase");
    idle_zero_a: assert property (!rd_data_valid |-> rd_data == 8'h00)
        else $error("data shown while idle");
    zero_unused_a: assert property (rd_data_valid && $past(result_sel) == 2'h0 |-> !rd_data[3])
        else $error("byte zero bit 3 set");
    three_fixed_a: assert property (rd_data_valid && $past(result_sel) == 2'h3
        |-> rd_data[5] && rd_data[3] && !rd_data[7]) else $error("byte three fixed bits");
    // Drive and head must come from the exec end cycle, not the read cycle
    exec_drive_a: assert property (exec_end ##1 (rd_req && result_sel == 2'h0)
        |=> rd_data[1:0] == $past(drive_sel, 2)) else $error("drive field wrong");
    exec_head_a: assert property (exec_end ##1 (rd_req && result_sel == 2'h0)
        |=> rd_data[2] == $past(head_side_select, 2)) else $error("head bit wrong");
    exec_code_a: assert property (exec_end && end_kind == 2'h1 && !poll_ready_change
        ##1 (rd_req && result_sel == 2'h0) |=> rd_data[7:6] == rsb_pkg::ic_abnormal)
        else $error("abnormal code wrong");
endmodule // rsb_status_checker
bind rsb_status rsb_status_checker chk (.clk, .reset, .host_addr, .host_rd, .result_phase,
    .result_sel, .exec_end, .end_kind, .drive_sel, .head_side_select, .poll_ready_change,
    .rd_data, .rd_data_valid);
`default_nettype wire

// File: rsb_host.sv
// Host processor model reading result bytes
`timescale 1ns/1ns
`default_nettype none
module rsb_host
(
    input wire logic clk,
    output logic host_rd,
    output logic [2:0] host_addr,
    output logic [1:0] result_sel,
    input wire logic [7:0] rd_data,
    input wire logic rd_data_valid
);
    // --------
    // Read cycle
    // --------
    initial
    begin
        host_rd = 1'b0;
        host_addr = 3'h2;
        result_sel = 2'h0;
    end
    task automatic read(input logic [2:0] a, input logic [1:0] s, output logic [8:0] r);
        host_rd <= 1'b1;
        host_addr <= a;
        result_sel <= s;
        @(posedge clk);
        // Inverse on release so a stale address never looks valid
        host_rd <= 1'b0;
        host_addr <= ~a;
        result_sel <= ~s;
        // Answer stands for the whole next cycle; take it mid-cycle, clear of the edge
        @(negedge clk);
        r = {rd_data_valid, rd_data};
        @(posedge clk);
    endtask
endmodule // rsb_host
`default_nettype wire

// File: rsb_status_tb.sv
// Testbench for the result status byte builder
`timescale 1ns/1ns
`default_nettype none
module rsb_status_tb;
    logic clk, reset, result_phase, head_side_select, track_zero_seen, is_write_cmd;
    logic terminal_count, scan_cond_met, track_zero_input_n, write_protect_n;
    logic host_rd, rd_data_valid;
    logic [1:0] end_kind, drive_sel, result_sel;
    logic [2:0] host_addr;
    logic [7:0] rd_data;
    logic [15:0] pl;
    logic am_in_data, crc_in_data;
    logic [7:0] rec_trk, cmd_trk;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    localparam int flag_ev [15] = '{7, 8, 9, 10, 11, 12, 13, 14, 15, 11, 13, 7, 10, 12, 12};
    localparam logic [7:0] exp_one [15] = '{8'h01, 8'h04, 8'h10, 8'h20, 8'h80, 8'h04, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h20, 8'h04, 8'h04};
    localparam logic [7:0] exp_two [15] = '{8'h01, 8'h00, 8'h00, 8'h20, 8'h00, 8'h12, 8'h04,
        8'h08, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
    // --------
    // Design and host
    // --------
    rsb_status dut
    (
        .clk, .reset, .soft_reset(pl[6]), .host_addr, .host_rd, .result_phase, .result_sel,
        .cmd_start(pl[0]), .cmd_phase_end(pl[1]), .exec_end(pl[2]), .end_kind, .drive_sel,
        .head_side_select, .poll_ready_change(pl[3]), .seek_done(pl[4]), .recal_done(pl[5]),
        .track_zero_seen, .ev_addr_mark_missing(pl[7]), .ev_am_in_data_field(am_in_data),
        .is_write_cmd, .ev_sector_not_found(pl[12]), .recorded_track(rec_trk),
        .command_track(cmd_trk), .ev_missing_data(pl[8]), .ev_overrun(pl[9]),
        .ev_crc_error(pl[10]), .ev_crc_in_data(crc_in_data), .ev_last_byte_eot(pl[11]),
        .terminal_count, .ev_scan_result(pl[13]), .scan_cond_met, .ev_scan_equal(pl[14]),
        .ev_control_mark(pl[15]), .track_zero_input_n, .write_protect_n, .rd_data,
        .rd_data_valid
    );
    rsb_host host (.clk, .host_rd, .host_addr, .result_sel, .rd_data, .rd_data_valid);
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            err_total++;
            complete_run;
        end
    end
    // --------
    // Helpers and scenarios
    // --------
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [1:0] s, input logic [7:0] e, input string nm);
        logic [8:0] r;
        host.read(3'h5, s, r);
        chk(nm, {1'b1, e}, r);
    endtask
    // Waits an edge first so one pulse never clears and sets in one step
    task automatic pulse(input int k);
        @(posedge clk);
        pl <= 16'h0001 << k;
        @(posedge clk);
        pl <= 16'h0000;
    endtask
    task automatic s_ready;
        pulse(3);
        rd(2'h0, 8'hc0, "ready after reset");
        pulse(0);
        pulse(3);
        rd(2'h0, 8'h00, "ready once only");
        pulse(6);
        pulse(3);
        rd(2'h0, 8'hc0, "ready after soft reset");
    endtask
    task automatic s_exec;
        for (int i = 0; i < 3; i++)
        begin
            drive_sel <= i[1:0];
            head_side_select <= i[0];
            end_kind <= i[1:0];
            pulse(0);
            pulse(2);
            rd(2'h0, {i[1:0], 3'h0, i[0], i[1:0]}, "exec byte zero");
        end
    endtask
    task automatic s_seek;
        track_zero_seen <= 1'b0;
        pulse(0);
        pulse(5);
        rd(2'h0, 8'h30, "recal missed");
        track_zero_seen <= 1'b1;
        pulse(0);
        pulse(5);
        rd(2'h0, 8'h20, "recal found");
        pulse(0);
        pulse(4);
        rd(2'h0, 8'h20, "seek end");
        pulse(0);
        rd(2'h0, 8'h00, "new command");
    endtask
    task automatic s_flags;
        for (int n = 0; n < 15; n++)
        begin
            terminal_count <= n == 9;
            scan_cond_met <= n == 10;
            am_in_data <= n != 11;
            crc_in_data <= n != 12;
            rec_trk <= n == 13 ? 8'h05 : (n == 14 ? 8'h07 : 8'hff);
            cmd_trk <= n == 14 ? 8'h07 : 8'h03;
            pulse(0);
            pulse(flag_ev[n]);
            rd(2'h1, exp_one[n], "byte one");
            rd(2'h2, exp_two[n], "byte two");
        end
    endtask
    task automatic s_three;
        write_protect_n <= 1'b0;
        track_zero_input_n <= 1'b0;
        drive_sel <= 2'h3;
        head_side_select <= 1'b1;
        is_write_cmd <= 1'b1;
        repeat (4) @(posedge clk);
        pulse(0);
        pulse(1);
        rd(2'h3, 8'h7f, "byte three set");
        rd(2'h1, 8'h02, "write protect");
        write_protect_n <= 1'b1;
        track_zero_input_n <= 1'b1;
        drive_sel <= 2'h0;
        repeat (4) @(posedge clk);
        rd(2'h3, 8'h2f, "byte three clear");
        pulse(0);
        pulse(1);
        rd(2'h1, 8'h00, "write enabled");
    endtask
    task automatic s_refuse;
        logic [8:0] r;
        host.read(3'h4, 2'h0, r);
        chk("other address", 9'h000, r);
        result_phase <= 1'b0;
        host.read(3'h5, 2'h0, r);
        chk("outside result phase", 9'h000, r);
        result_phase <= 1'b1;
    endtask
    initial
    begin
        reset = 1'b1;
        pl = 16'h0000;
        {result_phase, track_zero_input_n, write_protect_n, am_in_data, crc_in_data} = 5'h1f;
        {rec_trk, cmd_trk} = 16'hff03;
        {head_side_select, track_zero_seen, is_write_cmd, terminal_count, scan_cond_met} = 5'h00;
        {end_kind, drive_sel} = 4'h0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        s_ready;
        s_exec;
        s_seek;
        s_flags;
        s_three;
        s_refuse;
        complete_run;
    end
endmodule // rsb_status_tb
`default_nettype wire
